// File: design/pmcc_pkg.sv
// Package of constants for the power mode and clock controller
package pmcc_pkg;

    // ========================================================================
    // Register offsets (byte addresses on the plain register port)
    localparam logic [3:0] PMCC_OFF_MODE = 4'h0;
    localparam logic [3:0] PMCC_OFF_CTRL = 4'h4;
    localparam logic [3:0] PMCC_OFF_STAT = 4'h8;

    // ========================================================================
    // system_mode_register fields
    localparam int PMCC_MODE_DIV_LSB = 5;
    localparam int PMCC_MODE_LTO_BIT = 3;
    localparam int PMCC_MODE_HTO_BIT = 2;
    localparam int PMCC_MODE_IDLE_BIT = 1;
    localparam int PMCC_MODE_FAST_BIT = 0;

    // idle_and_reset_flags fields
    localparam int PMCC_CTRL_KEEP_BIT = 7;
    localparam int PMCC_CTRL_BOR_BIT = 2;
    localparam int PMCC_CTRL_LVC_BIT = 1;
    localparam int PMCC_CTRL_WCR_BIT = 0;

    // Status fields
    localparam int PMCC_STAT_PDF_BIT = 1;
    localparam int PMCC_STAT_TO_BIT = 0;

    // ========================================================================
    // Reset values
    localparam logic [2:0] PMCC_RST_DIV = 3'h0;
    localparam logic PMCC_RST_IDLE = 1'b1;
    localparam logic PMCC_RST_FAST = 1'b1;
    localparam logic PMCC_RST_KEEP = 1'b0;

    // Lowest divider code that still runs from the fast oscillator
    localparam logic [2:0] PMCC_DIV_FAST_MIN = 3'h2;
    localparam logic [2:0] PMCC_DIV_BY16 = 3'h4;
    localparam logic [2:0] PMCC_DIV_BY64 = 3'h2;

    // ========================================================================
    // Timing
    localparam int PMCC_CORE_CLK_HZ = 20_000_000;
    localparam int PMCC_SLOW_OSC_HZ = 32_000;
    localparam int PMCC_SLOW_DIV_CYC = PMCC_CORE_CLK_HZ / PMCC_SLOW_OSC_HZ;
    localparam int PMCC_HTO_CYC = 16;
    localparam int PMCC_LTO_TICKS = 2;

    // ========================================================================
    // Operating states
    typedef enum logic [2:0] {
        ST_RUN,
        ST_SLEEP,
        ST_CLOCK_STOPPED_STANDBY,
        ST_CLOCK_RUNNING_STANDBY,
        ST_WAKE
    } pmcc_state_e;

endpackage : pmcc_pkg

// File: design/pmcc_power_mode_clock_controller.sv
// Operating mode, system clock and reset-flag controller
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns

module pmcc_power_mode_clock_controller
    import pmcc_pkg::*;
#(
    parameter int SLOW_DIV_CYC = PMCC_SLOW_DIV_CYC,
    parameter int PORTA_W = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    input wire logic halt_req_i,
    input wire logic clr_wdt_i,
    input wire logic int_req_i,
    input wire logic wdt_overflow_i,
    input wire logic brownout_evt_i,
    input wire logic lvl_code_invalid_i,
    input wire logic wdt_ctl_invalid_i,
    input wire logic [PORTA_W-1:0] porta_pin_i,
    input wire logic [PORTA_W-1:0] porta_wake_en_i,
    output logic cpu_run_o,
    output logic sys_clk_en_o,
    output logic tbc_clk_en_o,
    output logic slow_clk_en_o,
    output logic fast_osc_en_o,
    output logic fast_div16_en_o,
    output logic fast_div64_en_o,
    output logic wdt_clear_o,
    output logic pc_sp_reset_o,
    output logic low_power_o,
    output logic high_osc_stable_o,
    output logic low_osc_stable_o,
    output logic power_down_flag_o,
    output logic watchdog_expiry_flag_o
);

    // ========================================================================
    // Helpers
    localparam int SLOW_CNT_W = $clog2(SLOW_DIV_CYC);
    localparam logic [SLOW_CNT_W-1:0] SLOW_LAST = SLOW_CNT_W'(SLOW_DIV_CYC - 1);
    localparam logic [4:0] HTO_LAST = 5'(PMCC_HTO_CYC);
    localparam logic [1:0] LTO_LAST = 2'(PMCC_LTO_TICKS);

    // Divider tick: code 010 gives one in 64 cycles, 111 one in 2
    function automatic logic pmcc_div_tick(input logic [5:0] cnt, input logic [2:0] sel);
        logic [5:0] mask;
        mask = 6'h3F >> (sel - PMCC_DIV_FAST_MIN);
        return &(cnt | ~mask);
    endfunction : pmcc_div_tick

    // ========================================================================
    // Registers
    pmcc_state_e state_ff;
    pmcc_state_e nxt_state;
    logic [2:0] div_sel_ff;
    logic idle_en_ff;
    logic fast_sel_ff;
    logic keep_ff;
    logic bor_flag_ff;
    logic lvc_flag_ff;
    logic wcr_flag_ff;
    logic pdf_ff;
    logic to_ff;
    logic [SLOW_CNT_W-1:0] slow_cnt_ff;
    logic [5:0] div_cnt_ff;
    logic [4:0] hto_cnt_ff;
    logic hto_ff;
    logic [1:0] lto_cnt_ff;
    logic lto_ff;
    logic [PORTA_W-1:0] pa_meta_ff;
    logic [PORTA_W-1:0] pa_sync_ff;
    logic [PORTA_W-1:0] pa_prev_ff;
    logic [7:0] rdata_ff;
    logic cpu_run_ff;
    logic sys_en_ff;
    logic tbc_en_ff;
    logic slow_en_ff;
    logic fast_osc_ff;
    logic div16_ff;
    logic div64_ff;
    logic wdt_clr_ff;
    logic pcsp_ff;
    logic low_pwr_ff;

    // ========================================================================
    // Register port decode
    wire wr_mode = reg_we_i && (reg_addr_i == PMCC_OFF_MODE);
    wire wr_ctrl = reg_we_i && (reg_addr_i == PMCC_OFF_CTRL);

    wire [7:0] mode_rd = {div_sel_ff, 1'b0, lto_ff, hto_ff, idle_en_ff, fast_sel_ff};
    wire [7:0] ctrl_rd = {keep_ff, 4'h0, bor_flag_ff, lvc_flag_ff, wcr_flag_ff};
    wire [7:0] stat_rd = {6'h00, pdf_ff, to_ff};
    wire [7:0] rd_mux = (reg_addr_i == PMCC_OFF_MODE) ? mode_rd :
                        (reg_addr_i == PMCC_OFF_CTRL) ? ctrl_rd :
                        (reg_addr_i == PMCC_OFF_STAT) ? stat_rd : 8'h00;

    // Software may only clear the reset-cause flags; a write of one leaves them alone
    wire clr_bor = wr_ctrl && !reg_wdata_i[PMCC_CTRL_BOR_BIT];
    wire clr_lvc = wr_ctrl && !reg_wdata_i[PMCC_CTRL_LVC_BIT];
    wire clr_wcr = wr_ctrl && !reg_wdata_i[PMCC_CTRL_WCR_BIT];

    // ========================================================================
    // Clock selection
    wire need_fast = fast_sel_ff || (div_sel_ff >= PMCC_DIV_FAST_MIN);
    wire slow_mode = !need_fast;
    wire slow_tick = (slow_cnt_ff == SLOW_LAST);

    wire low_pwr = (state_ff == ST_SLEEP) || (state_ff == ST_CLOCK_STOPPED_STANDBY)
                   || (state_ff == ST_CLOCK_RUNNING_STANDBY);

    // Fast oscillator runs only where a running or restarting (wake) system clock needs it
    wire fast_osc_nxt = need_fast && ((state_ff == ST_RUN) || (state_ff == ST_CLOCK_RUNNING_STANDBY)
                        || (state_ff == ST_WAKE));

    wire fast_tick = fast_sel_ff ? 1'b1 : pmcc_div_tick(div_cnt_ff, div_sel_ff);

    // Slow system clock is held until the slow oscillator reports stable
    wire sel_tick = need_fast ? (fast_osc_ff && fast_tick) : (slow_tick && lto_ff);

    wire sys_runs = (state_ff == ST_RUN) || (state_ff == ST_CLOCK_RUNNING_STANDBY);
    wire sys_tick = sys_runs && sel_tick;
    wire tbc_tick = slow_tick && (state_ff != ST_SLEEP);

    wire div16_tick = fast_osc_ff && pmcc_div_tick(div_cnt_ff, PMCC_DIV_BY16);
    wire div64_tick = fast_osc_ff && pmcc_div_tick(div_cnt_ff, PMCC_DIV_BY64);

    // ========================================================================
    // Halt and wake events
    wire halt_take = (state_ff == ST_RUN) && halt_req_i;
    wire [PORTA_W-1:0] pa_fall = pa_prev_ff & ~pa_sync_ff & porta_wake_en_i;
    wire wake_evt = low_pwr && ((|pa_fall) || int_req_i || wdt_overflow_i);
    wire wdt_wake = low_pwr && wdt_overflow_i;

    // Restarted clock must be stable before the CPU is let go
    wire clk_ready = need_fast ? hto_ff : lto_ff;

    // ========================================================================
    // Stability counters
    wire [4:0] nxt_hto_cnt = !fast_osc_ff ? 5'h00 :
                             (hto_cnt_ff == HTO_LAST) ? hto_cnt_ff : hto_cnt_ff + 5'h01;
    wire [1:0] nxt_lto_cnt = wake_evt ? 2'h0 :
                             (slow_tick && (lto_cnt_ff != LTO_LAST)) ? lto_cnt_ff + 2'h1 :
                             lto_cnt_ff;

    // ========================================================================
    // Output next values
    wire [7:0] nxt_rdata = reg_re_i ? rd_mux : 8'h00;
    wire nxt_cpu_run = (nxt_state == ST_RUN);
    wire nxt_low_pwr = (nxt_state != ST_RUN) && (nxt_state != ST_WAKE);
    // Stable flag falls with the oscillator enable, so it never reads high while stopped
    wire nxt_hto = fast_osc_nxt && (nxt_hto_cnt == HTO_LAST);
    wire nxt_lto = (nxt_lto_cnt == LTO_LAST);

    // ========================================================================
    // Flag next values; hardware set wins over a clear in the same cycle
    wire nxt_bor = brownout_evt_i || (bor_flag_ff && !clr_bor);
    wire nxt_lvc = lvl_code_invalid_i || (lvc_flag_ff && !clr_lvc);
    wire nxt_wcr = wdt_ctl_invalid_i || (wcr_flag_ff && !clr_wcr);
    wire nxt_pdf = halt_take || (pdf_ff && !clr_wdt_i);
    wire nxt_to = wdt_overflow_i || (to_ff && !halt_take);

    // ========================================================================
    // Mode state machine
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (halt_take) begin
                    if (!idle_en_ff) begin
                        nxt_state = ST_SLEEP;
                    end else if (keep_ff) begin
                        nxt_state = ST_CLOCK_RUNNING_STANDBY;
                    end else begin
                        nxt_state = ST_CLOCK_STOPPED_STANDBY;
                    end
                end
            end
            ST_SLEEP, ST_CLOCK_STOPPED_STANDBY, ST_CLOCK_RUNNING_STANDBY: begin
                if (wake_evt) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (clk_ready) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // ========================================================================
    // State and configuration
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_ff <= ST_RUN;
            div_sel_ff <= PMCC_RST_DIV;
            idle_en_ff <= PMCC_RST_IDLE;
            fast_sel_ff <= PMCC_RST_FAST;
            keep_ff <= PMCC_RST_KEEP;
        end else begin
            state_ff <= nxt_state;
            if (wr_mode) begin
                div_sel_ff <= reg_wdata_i[PMCC_MODE_DIV_LSB +: 3];
                idle_en_ff <= reg_wdata_i[PMCC_MODE_IDLE_BIT];
                fast_sel_ff <= reg_wdata_i[PMCC_MODE_FAST_BIT];
            end
            if (wr_ctrl) begin
                keep_ff <= reg_wdata_i[PMCC_CTRL_KEEP_BIT];
            end
        end
    end

    // Flags; a power-up clears the power-down flag
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bor_flag_ff <= 1'b0;
            lvc_flag_ff <= 1'b0;
            wcr_flag_ff <= 1'b0;
            pdf_ff <= 1'b0;
            to_ff <= 1'b0;
        end else begin
            bor_flag_ff <= nxt_bor;
            lvc_flag_ff <= nxt_lvc;
            wcr_flag_ff <= nxt_wcr;
            pdf_ff <= nxt_pdf;
            to_ff <= nxt_to;
        end
    end

    // ========================================================================
    // Oscillator dividers and stability
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            slow_cnt_ff <= '0;
            div_cnt_ff <= 6'h00;
        end else begin
            slow_cnt_ff <= slow_tick ? '0 : slow_cnt_ff + SLOW_CNT_W'(1);
            // Divider is cleared to zero while the fast oscillator is off
            div_cnt_ff <= fast_osc_ff ? div_cnt_ff + 6'h01 : 6'h00;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hto_cnt_ff <= 5'h00;
            hto_ff <= 1'b0;
            lto_cnt_ff <= 2'h0;
            lto_ff <= 1'b0;
        end else begin
            hto_cnt_ff <= nxt_hto_cnt;
            hto_ff <= nxt_hto;
            lto_cnt_ff <= nxt_lto_cnt;
            lto_ff <= nxt_lto;
        end
    end

    // ========================================================================
    // Port A wake synchroniser
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pa_meta_ff <= '1;
            pa_sync_ff <= '1;
            pa_prev_ff <= '1;
        end else begin
            pa_meta_ff <= porta_pin_i;
            pa_sync_ff <= pa_meta_ff;
            pa_prev_ff <= pa_sync_ff;
        end
    end

    // ========================================================================
    // Outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sys_en_ff <= 1'b0;
            tbc_en_ff <= 1'b0;
            slow_en_ff <= 1'b0;
        end else begin
            sys_en_ff <= sys_tick;
            tbc_en_ff <= tbc_tick;
            slow_en_ff <= slow_tick;
        end
    end

    // Fast oscillator and its divided enables
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            fast_osc_ff <= 1'b0;
            div16_ff <= 1'b0;
            div64_ff <= 1'b0;
        end else begin
            fast_osc_ff <= fast_osc_nxt;
            div16_ff <= div16_tick;
            div64_ff <= div64_tick;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cpu_run_ff <= 1'b0;
            low_pwr_ff <= 1'b0;
        end else begin
            cpu_run_ff <= nxt_cpu_run;
            low_pwr_ff <= nxt_low_pwr;
        end
    end

    // Memory, registers and ports are untouched by entry; only the watchdog restarts
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wdt_clr_ff <= 1'b0;
            pcsp_ff <= 1'b0;
        end else begin
            wdt_clr_ff <= halt_take;
            pcsp_ff <= wdt_wake;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign cpu_run_o = cpu_run_ff;
    assign sys_clk_en_o = sys_en_ff;
    assign tbc_clk_en_o = tbc_en_ff;
    assign slow_clk_en_o = slow_en_ff;
    assign fast_osc_en_o = fast_osc_ff;
    assign fast_div16_en_o = div16_ff;
    assign fast_div64_en_o = div64_ff;
    assign wdt_clear_o = wdt_clr_ff;
    assign pc_sp_reset_o = pcsp_ff;
    assign low_power_o = low_pwr_ff;
    assign high_osc_stable_o = hto_ff;
    assign low_osc_stable_o = lto_ff;
    assign power_down_flag_o = pdf_ff;
    assign watchdog_expiry_flag_o = to_ff;

endmodule : pmcc_power_mode_clock_controller

// File: verification/pmcc_props.sv
// Port-level checker for the power mode and clock controller
`timescale 1ns/1ns
module pmcc_props
    import pmcc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic halt_req_i,
    input wire logic clr_wdt_i,
    input wire logic int_req_i,
    input wire logic wdt_overflow_i,
    input wire logic cpu_run_o,
    input wire logic sys_clk_en_o,
    input wire logic tbc_clk_en_o,
    input wire logic fast_osc_en_o,
    input wire logic fast_div16_en_o,
    input wire logic fast_div64_en_o,
    input wire logic wdt_clear_o,
    input wire logic pc_sp_reset_o,
    input wire logic low_power_o,
    input wire logic high_osc_stable_o,
    input wire logic low_osc_stable_o,
    input wire logic power_down_flag_o,
    input wire logic watchdog_expiry_flag_o
);
    // ====================
    // Shadow of the mode bits, so the mode taken at halt is known
    logic fast_ff;
    logic idle_ff;
    logic keep_ff;
    logic [2:0] div_ff;
    logic [1:0] lp_mode_ff;
    wire mode_wr = reg_we_i && (reg_addr_i == PMCC_OFF_MODE);
    wire halt_taken = cpu_run_o && halt_req_i;
    wire fast_req = fast_ff || (div_ff >= PMCC_DIV_FAST_MIN);
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            fast_ff <= PMCC_RST_FAST;
            idle_ff <= PMCC_RST_IDLE;
            keep_ff <= PMCC_RST_KEEP;
            div_ff <= PMCC_RST_DIV;
            lp_mode_ff <= 2'h0;
        end else begin
            if (mode_wr) begin
                fast_ff <= reg_wdata_i[PMCC_MODE_FAST_BIT];
                idle_ff <= reg_wdata_i[PMCC_MODE_IDLE_BIT];
                div_ff <= reg_wdata_i[PMCC_MODE_DIV_LSB +: 3];
            end
            if (reg_we_i && (reg_addr_i == PMCC_OFF_CTRL)) begin
                keep_ff <= reg_wdata_i[PMCC_CTRL_KEEP_BIT];
            end
            if (halt_taken) begin
                lp_mode_ff <= {idle_ff, keep_ff};
            end
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    chk_halt_enter: assert property (halt_taken |=> low_power_o && !cpu_run_o)
        else $error("halt did not enter low power");
    chk_halt_flags: assert property (halt_taken && !wdt_overflow_i |=>
        power_down_flag_o && !watchdog_expiry_flag_o && wdt_clear_o)
        else $error("halt flags or watchdog clear wrong");
    chk_sleep_gates: assert property (low_power_o && $past(low_power_o) && !lp_mode_ff[1]
        |-> !sys_clk_en_o && !tbc_clk_en_o)
        else $error("clock ticks during sleep");
    chk_clock_stopped_standby_gates: assert property (low_power_o && $past(low_power_o)
        && lp_mode_ff == 2'h2 |-> !sys_clk_en_o && !fast_osc_en_o)
        else $error("system clock runs in stopped standby");
    chk_clock_running_standby_runs: assert property (halt_taken && idle_ff && keep_ff
        |-> ##[1:700] sys_clk_en_o)
        else $error("system clock stopped in running standby");
    chk_slow_fast_off: assert property (!fast_req && low_osc_stable_o && cpu_run_o
        |=> !fast_osc_en_o)
        else $error("fast oscillator left on in slow mode");
    chk_div_stop: assert property (!$past(fast_osc_en_o) && !fast_osc_en_o
        |-> !fast_div16_en_o && !fast_div64_en_o)
        else $error("divided fast clocks run while oscillator off");
    chk_hto_rise: assert property ($rose(fast_osc_en_o)
        |-> ##14 !high_osc_stable_o ##[1:2] high_osc_stable_o)
        else $error("fast oscillator stable flag timing wrong");
    chk_hto_low: assert property (low_power_o && $past(low_power_o) && !fast_osc_en_o
        |-> !high_osc_stable_o)
        else $error("fast stable flag high while oscillator stopped");
    chk_wdt_wake: assert property (low_power_o && wdt_overflow_i |=>
        pc_sp_reset_o && watchdog_expiry_flag_o && power_down_flag_o && !low_power_o)
        else $error("watchdog wake handled wrongly");
    chk_int_wake: assert property (low_power_o && int_req_i |=> !low_power_o && !cpu_run_o)
        else $error("interrupt did not wake");
    chk_run_stable: assert property ($rose(cpu_run_o) && !$past(rst_i, 2)
        |-> (fast_req ? high_osc_stable_o : low_osc_stable_o))
        else $error("cpu released before selected clock stable");
    chk_pdf_clear: assert property (clr_wdt_i && !halt_taken |=> !power_down_flag_o)
        else $error("clear watchdog left power down flag set");
endmodule : pmcc_props

bind pmcc_power_mode_clock_controller pmcc_props u_props (.*);

// File: verification/pmcc_cpu_model.sv
// Behavioural CPU core model: halt pulses and held interrupt requests
`timescale 1ns/1ns
module pmcc_cpu_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cpu_run_i,
    input wire logic halt_cmd_i,
    input wire logic int_cmd_i,
    output logic halt_req_o,
    output logic int_req_o
);
    // ====================
    // Halt is one cycle and only while running; interrupt stays until serviced
    always_ff @(posedge core_clk_i) begin
        halt_req_o <= !rst_i && halt_cmd_i && cpu_run_i && !halt_req_o;
        if (rst_i || (int_req_o && cpu_run_i)) begin
            int_req_o <= 1'b0;
        end else if (int_cmd_i) begin
            int_req_o <= 1'b1;
        end
    end
endmodule : pmcc_cpu_model

// File: verification/tb_pmcc_power_mode_clock_controller.sv
// Self-checking testbench of the power mode and clock controller
`timescale 1ns/1ns
module tb_pmcc_power_mode_clock_controller
    import pmcc_pkg::*;
();
    // ====================
    // Signals; slow divider shortened to keep the run short
    localparam int SDIV = 8;
    logic clk, rst, we, re, halt_req, int_req;
    logic [6:0] pls;
    wire clr_wdt = pls[6];
    wire wdt_ovf = pls[5];
    wire halt_cmd = pls[4];
    wire int_cmd = pls[3];
    wire [2:0] evt = pls[2:0];
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pins;
    logic run, sys, tbc, slw, fosc, d16, d64, lp;
    int err_total, cmp_count, cyc, ns, nt, n16, n64, nsl;
    pmcc_power_mode_clock_controller #(.SLOW_DIV_CYC(SDIV), .PORTA_W(8)) dut (
        .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .halt_req_i(halt_req),
        .clr_wdt_i(clr_wdt), .int_req_i(int_req), .wdt_overflow_i(wdt_ovf),
        .brownout_evt_i(evt[2]), .lvl_code_invalid_i(evt[1]), .wdt_ctl_invalid_i(evt[0]),
        .porta_pin_i(pins), .porta_wake_en_i(8'h01), .cpu_run_o(run), .sys_clk_en_o(sys),
        .tbc_clk_en_o(tbc), .slow_clk_en_o(slw), .fast_osc_en_o(fosc),
        .fast_div16_en_o(d16), .fast_div64_en_o(d64), .wdt_clear_o(), .pc_sp_reset_o(),
        .low_power_o(lp), .high_osc_stable_o(), .low_osc_stable_o(),
        .power_down_flag_o(), .watchdog_expiry_flag_o());
    pmcc_cpu_model cpu (.core_clk_i(clk), .rst_i(rst), .cpu_run_i(run),
        .halt_cmd_i(halt_cmd), .int_cmd_i(int_cmd), .halt_req_o(halt_req), .int_req_o(int_req));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ====================
    // Shared tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic rd_chk(input string w, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check(w, v, exp);
    endtask : rd_chk
    task automatic poll(input int b);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 60 && v[b] !== 1'b1; i++) rd(PMCC_OFF_MODE, v);
        check("poll", {7'h00, v[b]}, 8'h01);
    endtask : poll
    task automatic count();
        {ns, nt, n16, n64, nsl} = '0;
        repeat (128) begin
            @(posedge clk);
            #1;
            ns += (sys === 1'b1);
            nt += (tbc === 1'b1);
            n16 += (d16 === 1'b1);
            n64 += (d64 === 1'b1);
            nsl += (slw === 1'b1);
        end
    endtask : count
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        pls <= m;
        @(posedge clk);
        pls <= 7'h00;
    endtask : pulse
    // ====================
    // Scenarios
    task automatic t_reset();
        rd_chk("mode_rst", PMCC_OFF_MODE, 8'h03);
        poll(PMCC_MODE_HTO_BIT);
        poll(PMCC_MODE_LTO_BIT);
        rd_chk("ctrl_rst", PMCC_OFF_CTRL, 8'h00);
        rd_chk("unmapped", 4'hC, 8'h00);
        wr(PMCC_OFF_CTRL, 8'hFF);
        rd_chk("ctrl_rsvd", PMCC_OFF_CTRL, 8'h80);
        wr(PMCC_OFF_CTRL, 8'h00);
        wr(PMCC_OFF_MODE, 8'hF3);
        rd_chk("mode_ro", PMCC_OFF_MODE, 8'hEF);
        wr(PMCC_OFF_MODE, 8'h03);
    endtask : t_reset
    task automatic t_flags();
        for (int i = 0; i < 3; i++) begin
            pulse(7'(1 << i));
            wr(PMCC_OFF_CTRL, 8'h07);
            rd_chk("flag_set", PMCC_OFF_CTRL, 8'h01 << i);
            wr(PMCC_OFF_CTRL, 8'h00);
            rd_chk("flag_clr", PMCC_OFF_CTRL, 8'h00);
        end
    endtask : t_flags
    task automatic t_clocks();
        int per;
        for (int i = 0; i < 9; i++) begin
            wr(PMCC_OFF_MODE, (i < 8) ? {3'(i), 5'h02} : 8'h03);
            poll((i < 2) ? PMCC_MODE_LTO_BIT : PMCC_MODE_HTO_BIT);
            repeat (130) @(posedge clk);
            count();
            per = (i < 2) ? SDIV : (i == 8) ? 1 : 64 >> (i - 2);
            check("sys_rate", 8'(ns), 8'(128 / per));
            check("fast_osc", {7'h00, fosc}, (i < 2) ? 8'h00 : 8'h01);
            check("div16", 8'(n16), (i < 2) ? 8'h00 : 8'h08);
            check("div64", 8'(n64), (i < 2) ? 8'h00 : 8'h02);
        end
    endtask : t_clocks
    task automatic t_halt();
        for (int k = 0; k < 3; k++) begin
            wr(PMCC_OFF_MODE, (k == 0) ? 8'h01 : 8'h03);
            wr(PMCC_OFF_CTRL, (k == 2) ? 8'h80 : 8'h00);
            pulse(7'h20);
            pulse(7'h10);
            repeat (3) @(posedge clk);
            #1;
            check("low_power", {7'h00, lp}, 8'h01);
            rd_chk("stat_halt", PMCC_OFF_STAT, 8'h02);
            count();
            check("sys_lp", 8'(ns), (k == 2) ? 8'h80 : 8'h00);
            check("tbc_lp", 8'(nt), (k == 0) ? 8'h00 : 8'(128 / SDIV));
            check("slow_lp", 8'(nsl), 8'(128 / SDIV));
            if (k == 0) begin
                pulse(7'h08);
            end else if (k == 1) begin
                // A fall on a pin without wake enable must not wake
                @(posedge clk);
                pins <= 8'hFD;
                repeat (8) @(posedge clk);
                #1;
                check("masked_pin", {7'h00, lp}, 8'h01);
                @(posedge clk);
                pins <= 8'hFC;
            end else begin
                pulse(7'h20);
            end
            for (int i = 0; i < 60 && run !== 1'b1; i++) @(posedge clk);
            #1;
            check("woke", {7'h00, run}, 8'h01);
            pins <= 8'hFF;
            rd_chk("stat_wake", PMCC_OFF_STAT, (k == 2) ? 8'h03 : 8'h02);
            pulse(7'h40);
            rd_chk("stat_clr", PMCC_OFF_STAT, (k == 2) ? 8'h01 : 8'h00);
            rd_chk("ctrl_kept", PMCC_OFF_CTRL, (k == 2) ? 8'h80 : 8'h00);
        end
    endtask : t_halt
    // ====================
    // Run control; a hang is cut off well past the expected length
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        {rst, we, re} = 3'h4;
        pls = 7'h00;
        addr = 4'h0;
        wdata = 8'h00;
        pins = 8'hFF;
        {err_total, cmp_count, cyc} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_flags();
        t_clocks();
        t_halt();
        tally_and_finish();
    end
endmodule : tb_pmcc_power_mode_clock_controller
